// ===== rtl/aec_pkg.sv
// package of constants and types for the asynchronous event counter
// Operation
// - channel select 0: one 16-bit counter, low byte on low pin, high on carry
// - channel select 1: two independent 8-bit counters on high and low pins
// - high overflow flag set on high byte wrap FF to 00; software cannot set
// - in 16-bit mode high overflow flag marks the FFFF to 0000 wrap
// - low overflow flag set on low byte wrap only while channel select is 1
// - a flag clears only on write of 0 after reading it as 1
// - writes of 1 to the two flag bits have no effect
// - high count enable gates the selected high source; 0 holds the value
// - low count enable gates the low pin; 0 holds the value
// - high release bit 0 holds high counter at zero; 1 lets it count
// - low release bit 0 holds low counter at zero; 1 lets it count
// - bit 5 of the control register is plain storage, reset 0
// - reset clears the control register: 16-bit mode, disabled, held
// - counting follows event edges regardless of the cpu clocks
// - 16-bit mode counts 65536 events before wrapping
// - an overflow raises an interrupt request without software help
// - overflow sets the request flag; interrupt goes out only when enabled
// - a wrapped byte restarts from zero and keeps counting
// - standby bit 0 halts the counters and freezes the control register
// - in low power modes counters count but overflow flags are not set; the request flag still is
package aec_pkg;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_CTRL = 16'hFF95;
  localparam logic [15:0] IDX_CNT_H = 16'hFF96;
  localparam logic [15:0] IDX_CNT_L = 16'hFF97;
  localparam logic [15:0] IDX_IRQ_REQ = 16'hFF98;
  localparam logic [15:0] IDX_IRQ_EN = 16'hFF99;
  localparam logic [15:0] IDX_PWR = 16'hFF9A;
  localparam logic [15:0] IDX_CKSTP = 16'hFFFB;
  // control field positions, and the standby bit of the clock stop register
  localparam int B_HI_OVF = 7;
  localparam int B_LO_OVF = 6;
  localparam int B_SPLIT = 4;
  localparam int B_HI_EN = 3;
  localparam int B_LO_EN = 2;
  localparam int B_RELH = 1;
  localparam int B_RELL = 0;
  localparam int B_STBY = 3;
  // reset values, counter maximum, clock stop read-back nibble and control write mask
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [3:0] CKSTP_RST = 4'hF;
  localparam logic [3:0] CKSTP_HI = 4'hF;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] CTRL_WMASK = 8'h3F;

  typedef struct packed {
    logic read;
    logic write;
    logic [17:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } aec_av_req_t;

  typedef struct packed {
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] prev;
    logic [7:0] ctrl;
    logic [7:0] cnt_h;
    logic [7:0] cnt_l;
    logic [3:0] ckstp;
    logic irq_req;
    logic irq_en;
    logic lowpwr;
    logic arm_h;
    logic arm_l;
    logic ack;
    logic [31:0] rdata;
    logic irq;
  } aec_state_t;
endpackage : aec_pkg

// ===== rtl/aec_top.sv
// asynchronous event counter with avalon-mm register slave
//
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/10ps
module aec_top (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // event pins
  input wire logic event_pin_high_i,
  input wire logic event_pin_low_i,
  // avalon-mm slave
  input wire aec_pkg::aec_av_req_t av_req_i,
  output logic [31:0] av_readdata_o,
  output logic av_waitrequest_o,
  // interrupt to the processor
  output logic irq_o
);
  aec_pkg::aec_state_t s;
  aec_pkg::aec_state_t n;
  logic [1:0] edge_v;
  logic run;
  logic inc_l;
  logic inc_h;
  logic wrap_l;
  logic wrap_h;
  logic take;
  logic wr_ok;
  logic [15:0] idx;
  logic [31:0] rmux;

  always_comb begin
    n = s;
    edge_v = 2'h0;
    run = 1'b0;
    inc_l = 1'b0;
    inc_h = 1'b0;
    wrap_l = 1'b0;
    wrap_h = 1'b0;
    take = 1'b0;
    wr_ok = 1'b0;
    idx = av_req_i.address[17:2];
    rmux = 32'h0;
    // first stage feeds only the second stage
    n.sync1 = {event_pin_high_i, event_pin_low_i};
    n.sync2 = s.sync1;
    n.prev = s.sync2;
    edge_v = s.sync2 & ~s.prev;
    // counting: pins sampled here, cpu clock gating is not modelled
    run = s.ckstp[aec_pkg::B_STBY];
    inc_l = run && edge_v[0] && s.ctrl[aec_pkg::B_LO_EN] && s.ctrl[aec_pkg::B_RELL];
    wrap_l = inc_l && (s.cnt_l == aec_pkg::CNT_MAX);
    if (s.ctrl[aec_pkg::B_SPLIT]) begin
      inc_h = run && edge_v[1];
    end else begin
      inc_h = wrap_l;
    end
    inc_h = inc_h && s.ctrl[aec_pkg::B_HI_EN] && s.ctrl[aec_pkg::B_RELH];
    wrap_h = inc_h && (s.cnt_h == aec_pkg::CNT_MAX);
    if (run && !s.ctrl[aec_pkg::B_RELL]) begin
      n.cnt_l = aec_pkg::CNT_RST;
    end else if (inc_l) begin
      n.cnt_l = s.cnt_l + 8'h01;
    end
    if (run && !s.ctrl[aec_pkg::B_RELH]) begin
      n.cnt_h = aec_pkg::CNT_RST;
    end else if (inc_h) begin
      n.cnt_h = s.cnt_h + 8'h01;
    end
    // bus handshake: one wait cycle, then waitrequest low for one cycle
    take = (av_req_i.read || av_req_i.write) && s.ack;
    n.ack = (av_req_i.read || av_req_i.write) && !s.ack;
    if (idx == aec_pkg::IDX_CTRL) begin
      rmux = {24'h0, s.ctrl};
    end else if (idx == aec_pkg::IDX_CNT_H) begin
      rmux = {24'h0, s.cnt_h};
    end else if (idx == aec_pkg::IDX_CNT_L) begin
      rmux = {24'h0, s.cnt_l};
    end else if (idx == aec_pkg::IDX_IRQ_REQ) begin
      rmux = {31'h0, s.irq_req};
    end else if (idx == aec_pkg::IDX_IRQ_EN) begin
      rmux = {31'h0, s.irq_en};
    end else if (idx == aec_pkg::IDX_PWR) begin
      rmux = {31'h0, s.lowpwr};
    end else if (idx == aec_pkg::IDX_CKSTP) begin
      rmux = {24'h0, aec_pkg::CKSTP_HI, s.ckstp};
    end
    if (n.ack) begin
      n.rdata = av_req_i.read ? rmux : 32'h0;
    end
    wr_ok = take && av_req_i.write && av_req_i.byteenable[0];
    // a read that shows a flag at 1 arms its clear
    if (take && av_req_i.read && idx == aec_pkg::IDX_CTRL) begin
      n.arm_h = s.arm_h || s.ctrl[aec_pkg::B_HI_OVF];
      n.arm_l = s.arm_l || s.ctrl[aec_pkg::B_LO_OVF];
    end
    // control register is frozen in module standby
    if (wr_ok && idx == aec_pkg::IDX_CTRL && run) begin
      n.ctrl = (s.ctrl & ~aec_pkg::CTRL_WMASK)
             | (av_req_i.writedata[7:0] & aec_pkg::CTRL_WMASK);
      // only a 0 clears, and only when armed; a 1 is ignored
      if (!av_req_i.writedata[aec_pkg::B_HI_OVF] && s.arm_h) begin
        n.ctrl[aec_pkg::B_HI_OVF] = 1'b0;
      end
      if (!av_req_i.writedata[aec_pkg::B_LO_OVF] && s.arm_l) begin
        n.ctrl[aec_pkg::B_LO_OVF] = 1'b0;
      end
      n.arm_h = 1'b0;
      n.arm_l = 1'b0;
    end
    if (wr_ok && idx == aec_pkg::IDX_IRQ_REQ && !av_req_i.writedata[0]) begin
      n.irq_req = 1'b0;
    end
    if (wr_ok && idx == aec_pkg::IDX_IRQ_EN) begin
      n.irq_en = av_req_i.writedata[0];
    end
    if (wr_ok && idx == aec_pkg::IDX_PWR) begin
      n.lowpwr = av_req_i.writedata[0];
    end
    if (wr_ok && idx == aec_pkg::IDX_CKSTP) begin
      n.ckstp = av_req_i.writedata[3:0];
    end
    // hardware set wins over a clear in the same cycle
    if (wrap_h && !s.lowpwr) begin
      n.ctrl[aec_pkg::B_HI_OVF] = 1'b1;
    end
    if (wrap_l && s.ctrl[aec_pkg::B_SPLIT] && !s.lowpwr) begin
      n.ctrl[aec_pkg::B_LO_OVF] = 1'b1;
    end
    if (wrap_h || (wrap_l && s.ctrl[aec_pkg::B_SPLIT])) begin
      n.irq_req = 1'b1;
    end
    n.irq = n.irq_req && n.irq_en;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
      s.ctrl <= aec_pkg::CTRL_RST;
      s.cnt_h <= aec_pkg::CNT_RST;
      s.cnt_l <= aec_pkg::CNT_RST;
      s.ckstp <= aec_pkg::CKSTP_RST;
    end else begin
      s <= n;
    end
  end

  assign av_readdata_o = s.rdata;
  assign av_waitrequest_o = !s.ack;
  assign irq_o = s.irq;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_low_release: assert property (
    (s.ckstp[3] && !s.ctrl[0]) |=> (s.cnt_l == 8'h00))
    else $error("low counter not held at zero");
  a_high_release: assert property (
    (s.ckstp[3] && !s.ctrl[1]) |=> (s.cnt_h == 8'h00))
    else $error("high counter not held at zero");
  a_low_enable_hold: assert property (
    (!s.ctrl[2] && s.ctrl[0]) |=> (s.cnt_l == $past(s.cnt_l)))
    else $error("low counter moved while disabled");
  a_high_enable_hold: assert property (
    (!s.ctrl[3] && s.ctrl[1]) |=> (s.cnt_h == $past(s.cnt_h)))
    else $error("high counter moved while disabled");
  a_hi_flag_wrap: assert property (
    $rose(s.ctrl[7]) |-> ($past(s.cnt_h) == 8'hFF && s.cnt_h == 8'h00))
    else $error("high flag set without wrap");
  a_lo_flag_split: assert property (
    $rose(s.ctrl[6]) |-> ($past(s.ctrl[4]) && $past(s.cnt_l) == 8'hFF))
    else $error("low flag set outside split mode");
  a_flags_lowpwr: assert property (
    ($rose(s.ctrl[7]) || $rose(s.ctrl[6])) |-> !$past(s.lowpwr))
    else $error("flag set in low power mode");
  a_hi_flag_clear: assert property (
    $fell(s.ctrl[7]) |-> $past(s.arm_h && av_req_i.write && s.ack))
    else $error("high flag cleared without read then write");
  a_standby_halt: assert property (
    !s.ckstp[3] |=> (s.cnt_l == $past(s.cnt_l) && s.ctrl == $past(s.ctrl)))
    else $error("counter moved in module standby");
  a_irq_on_ovf: assert property (
    ($rose(s.ctrl[7]) || $rose(s.ctrl[6])) |-> s.irq_req ##1 (s.irq == s.irq_en))
    else $error("overflow did not raise request");
  a_carry_16bit: assert property (
    (!s.ctrl[4] && s.cnt_h != $past(s.cnt_h) && $past(s.ctrl[1]))
      |-> ($past(s.cnt_l) == 8'hFF && s.cnt_l == 8'h00))
    else $error("high byte moved without low carry");
  a_bus_answer: assert property (
    ((av_req_i.read || av_req_i.write) && !s.ack) |=> s.ack)
    else $error("no answer one cycle after request");

  a_wait_idle: assert property (
    !(av_req_i.read || av_req_i.write)
      |=> av_waitrequest_o)
    else $error("answer without request");

  a_wait_one: assert property (
    !av_waitrequest_o
      |=> av_waitrequest_o)
    else $error("waitrequest low for more than one cycle");

  a_rdata_hold: assert property (
    !(av_req_i.read || av_req_i.write)
      |=> $stable(av_readdata_o))
    else $error("read data moved without request");

  a_rdata_write: assert property (
    (av_req_i.write && !s.ack)
      |=> (av_readdata_o == 32'h0000_0000))
    else $error("read data not zero on write");

  a_rdata_upper: assert property (
    1'b1
      |-> (av_readdata_o[31:8] == 24'h00_0000))
    else $error("upper read data bits not zero");

  a_rd_ctrl: assert property (
    (av_req_i.read && !s.ack && av_req_i.address[17:2] == aec_pkg::IDX_CTRL)
      |=> (av_readdata_o == {24'h00_0000, $past(s.ctrl)}))
    else $error("control read data wrong");

  a_rd_cnt_h: assert property (
    (av_req_i.read && !s.ack && av_req_i.address[17:2] == aec_pkg::IDX_CNT_H)
      |=> (av_readdata_o == {24'h00_0000, $past(s.cnt_h)}))
    else $error("high count read data wrong");

  a_rd_cnt_l: assert property (
    (av_req_i.read && !s.ack && av_req_i.address[17:2] == aec_pkg::IDX_CNT_L)
      |=> (av_readdata_o == {24'h00_0000, $past(s.cnt_l)}))
    else $error("low count read data wrong");

  a_rd_ckstp: assert property (
    (av_req_i.read && !s.ack && av_req_i.address[17:2] == aec_pkg::IDX_CKSTP)
      |=> (av_readdata_o == {24'h00_0000, 4'hF, $past(s.ckstp)}))
    else $error("clock stop read data wrong");

  a_irq_level: assert property (
    1'b1
      |-> (irq_o == (s.irq_req && s.irq_en)))
    else $error("interrupt not request and enable");

  a_irq_fell: assert property (
    $fell(irq_o)
      |-> $past(av_req_i.write && s.ack))
    else $error("interrupt dropped without a write");

  a_irq_req_keep: assert property (
    (s.irq_req && !(av_req_i.write && s.ack))
      |=> s.irq_req)
    else $error("request flag lost without a write");

  a_irq_req_fell: assert property (
    $fell(s.irq_req)
      |-> $past(av_req_i.write && s.ack))
    else $error("request flag cleared without a write");

  a_irq_req_set: assert property (
    ($past(s.cnt_h) == 8'hFF && s.cnt_h == 8'h00 && $past(s.ctrl[1]))
      |-> s.irq_req)
    else $error("high wrap did not raise request");

  a_irq_en_write: assert property (
    (av_req_i.write && s.ack && av_req_i.byteenable[0]
      && av_req_i.address[17:2] == aec_pkg::IDX_IRQ_EN) |=> (s.irq_en == $past(av_req_i.writedata[0])))
    else $error("enable write not stored");

  a_irq_en_keep: assert property (
    !(av_req_i.write && s.ack)
      |=> $stable(s.irq_en))
    else $error("enable moved without a write");

  a_ckstp_write: assert property (
    (av_req_i.write && s.ack && av_req_i.byteenable[0]
      && av_req_i.address[17:2] == aec_pkg::IDX_CKSTP) |=> (s.ckstp == $past(av_req_i.writedata[3:0])))
    else $error("clock stop write not stored");

  a_ckstp_keep: assert property (
    !(av_req_i.write && s.ack)
      |=> $stable(s.ckstp))
    else $error("clock stop moved without a write");

  a_pwr_write: assert property (
    (av_req_i.write && s.ack && av_req_i.byteenable[0]
      && av_req_i.address[17:2] == aec_pkg::IDX_PWR) |=> (s.lowpwr == $past(av_req_i.writedata[0])))
    else $error("low power write not stored");

  a_pwr_keep: assert property (
    !(av_req_i.write && s.ack)
      |=> $stable(s.lowpwr))
    else $error("low power moved without a write");

  a_ctrl_low_keep: assert property (
    !(av_req_i.write && s.ack && av_req_i.byteenable[0])
      |=> $stable(s.ctrl[5:0]))
    else $error("control bits moved without a write");

  a_hi_flag_keep: assert property (
    (s.ctrl[7] && !(av_req_i.write && s.ack))
      |=> s.ctrl[7])
    else $error("high flag lost without a write");

  a_lo_flag_keep: assert property (
    (s.ctrl[6] && !(av_req_i.write && s.ack))
      |=> s.ctrl[6])
    else $error("low flag lost without a write");

  a_lo_flag_clear: assert property (
    $fell(s.ctrl[6])
      |-> $past(s.arm_l && av_req_i.write && s.ack))
    else $error("low flag cleared without read then write");

  a_hi_arm_read: assert property (
    $rose(s.arm_h)
      |-> $past(av_req_i.read && s.ack && s.ctrl[7]))
    else $error("high clear armed without reading a one");

  a_lo_arm_read: assert property (
    $rose(s.arm_l)
      |-> $past(av_req_i.read && s.ack && s.ctrl[6]))
    else $error("low clear armed without reading a one");

  a_arm_drop: assert property (
    (av_req_i.write && s.ack && av_req_i.byteenable[0] && s.ckstp[3]
      && av_req_i.address[17:2] == aec_pkg::IDX_CTRL) |=> (!s.arm_h && !s.arm_l))
    else $error("clear still armed after a control write");

  a_hi_standby_halt: assert property (
    !s.ckstp[3]
      |=> (s.cnt_h == $past(s.cnt_h)))
    else $error("high counter moved in module standby");

  a_lo_step: assert property (
    (s.cnt_l != $past(s.cnt_l))
      |-> (s.cnt_l == 8'($past(s.cnt_l) + 8'h01) || s.cnt_l == 8'h00))
    else $error("low counter jumped");

  a_hi_step: assert property (
    (s.cnt_h != $past(s.cnt_h))
      |-> (s.cnt_h == 8'($past(s.cnt_h) + 8'h01) || s.cnt_h == 8'h00))
    else $error("high counter jumped");

  a_sync_stage: assert property (
    1'b1
      |-> (s.sync2 == $past(s.sync1)))
    else $error("second sync stage skipped");

  a_prev_stage: assert property (
    1'b1
      |-> (s.prev == $past(s.sync2)))
    else $error("edge detector not fed by second stage");

  a_lo_edge_only: assert property (
    (s.cnt_l != $past(s.cnt_l) && s.cnt_l != 8'h00)
      |-> $past(s.sync2[0] && !s.prev[0]))
    else $error("low counter moved without an event edge");

  a_hi_edge_split: assert property (
    (s.ctrl[4] && $past(s.ctrl[4]) && s.cnt_h != $past(s.cnt_h) && s.cnt_h != 8'h00)
      |-> $past(s.sync2[1] && !s.prev[1]))
    else $error("high counter moved without its own edge");

  a_split_hi_hold: assert property (
    (s.ctrl[4] && $past(s.ctrl[4]) && $past(s.ctrl[1]) && !$past(s.sync2[1] && !s.prev[1]))
      |-> (s.cnt_h == $past(s.cnt_h)))
    else $error("high counter moved without high pin edge");

  a_carry_step: assert property (
    (!s.ctrl[4] && s.ctrl[3] && s.ctrl[2] && s.ctrl[1] && s.ctrl[0] && s.ckstp[3]
      && s.cnt_l == 8'hFF && s.sync2[0] && !s.prev[0]) |=> (s.cnt_h == 8'($past(s.cnt_h) + 8'h01)))
    else $error("low carry did not step the high byte");
endmodule : aec_top

// ===== test/aec_event_src.sv
// event source model driving the two event pins
`timescale 1ns/10ps
module aec_event_src (
  // event pins
  output logic event_pin_high_o,
  output logic event_pin_low_o
);
  // pins rest low between bursts, like an idle source
  initial begin
    event_pin_high_o = 1'b0;
    event_pin_low_o = 1'b0;
  end
  // 800 ns event period, every edge 37 ns after a system clock rising edge
  task automatic pulse(input logic hi, input int n);
    #37;
    repeat (n) begin
      if (hi) event_pin_high_o = 1'b1;
      else event_pin_low_o = 1'b1;
      #400;
      event_pin_high_o = 1'b0;
      event_pin_low_o = 1'b0;
      #400;
    end
  endtask : pulse
endmodule : aec_event_src

// ===== test/tb_async_event_counter.sv
// self-checking bench for the event counter register slave
`timescale 1ns/10ps
module tb_async_event_counter;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  aec_pkg::aec_av_req_t req = '0;
  logic [31:0] rdata;
  logic wreq;
  logic irq;
  logic ev_h;
  logic ev_l;
  logic [7:0] rd;
  int errors = 0;
  int n_tests = 0;
  always #50 sys_clk_i = ~sys_clk_i;
  aec_event_src src (.event_pin_high_o(ev_h), .event_pin_low_o(ev_l));
  aec_top DUT (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .event_pin_high_i(ev_h), .event_pin_low_i(ev_l),
    .av_req_i(req), .av_readdata_o(rdata), .av_waitrequest_o(wreq), .irq_o(irq)
  );
  task automatic final_report;
    $display("checks %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one bus transfer; request held until waitrequest is seen low
  task automatic acc(input logic w, input logic [15:0] idx, input logic [7:0] wd);
    aec_pkg::aec_av_req_t r;
    int n;
    r = '{read: ~w, write: w, address: {idx, 2'b00}, byteenable: 4'hF,
      writedata: {24'h0, wd}};
    n = 0;
    @(posedge sys_clk_i);
    req <= r;
    // look at waitrequest mid-cycle, where it is settled, then finish on the take edge
    do begin
      @(negedge sys_clk_i);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    rd = rdata[7:0];
    if (n >= 20) errors++;
    @(posedge sys_clk_i);
    req <= '0;
  endtask : acc
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    acc(1'b1, idx, d);
  endtask : wr
  task automatic rdc(input logic [15:0] idx, input logic [7:0] exp);
    acc(1'b0, idx, 8'h00);
    chk(rd, exp);
  endtask : rdc
  initial begin
    #3_000_000;
    errors++;
    final_report();
  end
  initial begin
    repeat (2) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    @(posedge sys_clk_i);
    rdc(aec_pkg::IDX_CTRL, 8'h00);
    rdc(aec_pkg::IDX_CNT_H, 8'h00);
    rdc(aec_pkg::IDX_CNT_L, 8'h00);
    rdc(aec_pkg::IDX_CKSTP, 8'hFF);
    rdc(16'hFF00, 8'h00);
    wr(aec_pkg::IDX_CTRL, 8'hFF);
    rdc(aec_pkg::IDX_CTRL, 8'h3F);
    // enables on but release held low: counters must stay at zero
    wr(aec_pkg::IDX_CTRL, 8'h0C);
    src.pulse(1'b0, 3);
    rdc(aec_pkg::IDX_CNT_L, 8'h00);
    wr(aec_pkg::IDX_CTRL, 8'h0F);
    src.pulse(1'b0, 5);
    rdc(aec_pkg::IDX_CNT_L, 8'h05);
    wr(aec_pkg::IDX_CTRL, 8'h0B);
    src.pulse(1'b0, 2);
    rdc(aec_pkg::IDX_CNT_L, 8'h05);
    wr(aec_pkg::IDX_CTRL, 8'h0F);
    src.pulse(1'b0, 251);
    rdc(aec_pkg::IDX_CNT_L, 8'h00);
    rdc(aec_pkg::IDX_CNT_H, 8'h01);
    rdc(aec_pkg::IDX_CTRL, 8'h0F);
    src.pulse(1'b0, 2);
    rdc(aec_pkg::IDX_CNT_L, 8'h02);
    // split mode: high pin drives the high byte on its own
    wr(aec_pkg::IDX_CTRL, 8'h1C);
    rdc(aec_pkg::IDX_CNT_H, 8'h00);
    wr(aec_pkg::IDX_CTRL, 8'h1F);
    src.pulse(1'b1, 255);
    rdc(aec_pkg::IDX_CNT_H, 8'hFF);
    rdc(aec_pkg::IDX_CNT_L, 8'h00);
    src.pulse(1'b1, 1);
    rdc(aec_pkg::IDX_IRQ_REQ, 8'h01);
    chk({7'h00, irq}, 8'h00);
    wr(aec_pkg::IDX_CTRL, 8'h1F);
    rdc(aec_pkg::IDX_CTRL, 8'h9F);
    wr(aec_pkg::IDX_CTRL, 8'h1F);
    rdc(aec_pkg::IDX_CTRL, 8'h1F);
    wr(aec_pkg::IDX_IRQ_EN, 8'h01);
    @(posedge sys_clk_i);
    chk({7'h00, irq}, 8'h01);
    wr(aec_pkg::IDX_IRQ_REQ, 8'h00);
    @(posedge sys_clk_i);
    chk({7'h00, irq}, 8'h00);
    src.pulse(1'b0, 256);
    rdc(aec_pkg::IDX_CTRL, 8'h5F);
    rdc(aec_pkg::IDX_CNT_L, 8'h00);
    // module standby freezes counts and the control register
    wr(aec_pkg::IDX_CKSTP, 8'hF7);
    src.pulse(1'b1, 2);
    rdc(aec_pkg::IDX_CNT_H, 8'h00);
    wr(aec_pkg::IDX_CTRL, 8'h00);
    rdc(aec_pkg::IDX_CTRL, 8'h5F);
    wr(aec_pkg::IDX_CKSTP, 8'hFF);
    wr(aec_pkg::IDX_CTRL, 8'h1F);
    // low power: counting goes on, flags stay untouched
    wr(aec_pkg::IDX_PWR, 8'h01);
    src.pulse(1'b1, 256);
    rdc(aec_pkg::IDX_CNT_H, 8'h00);
    rdc(aec_pkg::IDX_CTRL, 8'h1F);
    final_report();
  end
endmodule : tb_async_event_counter
